// file: verilog/timer3_regs.vh
// register offsets, control bit positions and timing constants for timer three
`ifndef TIMER3_REGS_VH
`define TIMER3_REGS_VH

// ----------------------------------------
// register offsets on the sfr bus
// ----------------------------------------
`define CTRL_ADDR 8'h91
`define RELOAD_LOW_ADDR 8'h92
`define RELOAD_HIGH_ADDR 8'h93
`define COUNT_LOW_ADDR 8'h94
`define COUNT_HIGH_ADDR 8'h95

// ----------------------------------------
// control register bit positions
// ----------------------------------------
`define BIT_HIGH_OVF 7
`define BIT_LOW_OVF 6
`define BIT_LOW_IRQ_EN 5
`define BIT_CAPTURE_EN 4
`define BIT_SPLIT 3
`define BIT_RUN 2
`define SRC_MSB 1
`define SRC_LSB 0

// ----------------------------------------
// reset values and source codes
// ----------------------------------------
`define BYTE_RESET 8'h00
`define BYTE_MAX 8'hFF
`define CTRL_RESET 8'h00
`define SRC_SYS_A 2'h0
`define SRC_EXT_OSC 2'h1
`define SRC_SYS_B 2'h2
`define SRC_CMP 2'h3

// ----------------------------------------
// divider terminal counts
// ----------------------------------------
`define SYS_DIV 4'hC
`define SYS_DIV_LAST 4'hB
`define DIV_ZERO 4'h0
`define DIV_ONE 4'h1
`define OSC_DIV_LAST 3'h7
`define OSC_DIV_ZERO 3'h0
`define OSC_DIV_ONE 3'h1

`endif

// file: verilog/auto_reload_timer_three.v
// auto-reload timer three: 16-bit or split 8-bit, with capture
//
// Contract
// - split bit 0 gives one 16-bit reload timer, 1 gives two 8-bit
// - outside split mode count only while run control is 1; hold otherwise
// - in split mode run gates high byte only; low byte always runs
// - source 00/10 system_clock_source/12, 01 oscillator/8, 11 comparator 1
// - capture trigger: codes 00/01 comparator 1, 10/11 oscillator/8
// - in split mode the chosen external clock feeds both bytes
// - per-byte clock pick chooses external clock or system clock; 16-bit mode uses the low byte pick only
// - external sources synchronized to system clock before counting
// - two rw reload bytes, reset to zero
// - count bytes form the rw 16-bit counter, reset zero
// - in split mode each count byte is its own 8-bit timer
// - low overflow flag sets on every low byte rollover
// - high flag sets on high overflow (not on the capture-mode 16-bit wrap) and on each capture; only software clears flags
// - low irq enable plus timer irq enable: low overflow requests irq
// - capture enable 1 puts timer in capture mode
`timescale 1ns/10ps
`include "timer3_regs.vh"

module auto_reload_timer_three (
	input wire ref_clk, // system clock, 50 MHz
	input wire reset, // synchronous, active high
	input wire [7:0] sfr_addr, // register address
	input wire [7:0] sfr_wdata, // write data
	input wire sfr_wr, // write strobe, one cycle
	input wire sfr_rd, // read strobe, one cycle
	output reg [7:0] sfr_rdata, // read data, valid cycle after sfr_rd
	input wire high_byte_clock_pick, // 1: high byte counts system clock
	input wire low_byte_clock_pick, // 1: low byte counts system clock
	input wire timer_irq_enable, // global timer interrupt enable
	input wire ext_osc_clk, // external oscillator level
	input wire comparator1_out, // comparator 1 output level
	output reg irq_request // timer interrupt request level
);

// ----------------------------------------
// state
// ----------------------------------------
reg [7:0] reload_value_low;
reg [7:0] reload_value_high;
reg [7:0] count_value_low;
reg [7:0] count_value_high;
reg [7:0] ctrl;
reg [1:0] osc_sync;
reg [1:0] cmp_sync;
reg osc_prev;
reg cmp_prev;
reg [3:0] sys_div;
reg [2:0] osc_div;
reg osc_div_tick;
wire osc_rise;
wire cmp_rise;
wire sys12_tick;
reg ext_tick;
reg cap_tick;
wire split_mode_select;
wire run_control;
wire capture_enable;
wire [1:0] external_source_select;
wire low_en;
wire high_en;
wire low_step;
wire high_step;
wire low_wrap;
wire high_wrap;
reg [7:0] next_low;
reg [7:0] next_high;
reg next_low_ovf;
reg next_high_ovf;

assign split_mode_select = ctrl[`BIT_SPLIT];
assign run_control = ctrl[`BIT_RUN];
assign capture_enable = ctrl[`BIT_CAPTURE_EN];
assign external_source_select = ctrl[`SRC_MSB:`SRC_LSB];

// ----------------------------------------
// synchronizers; first stage read only by the second
// ----------------------------------------
always @(posedge ref_clk) begin
	if (reset) begin
		osc_sync <= 2'h0;
		cmp_sync <= 2'h0;
		osc_prev <= 1'b0;
		cmp_prev <= 1'b0;
	end else begin
		osc_sync <= {osc_sync[0], ext_osc_clk};
		cmp_sync <= {cmp_sync[0], comparator1_out};
		osc_prev <= osc_sync[1];
		cmp_prev <= cmp_sync[1];
	end
end

assign osc_rise = osc_sync[1] & ~osc_prev;
assign cmp_rise = cmp_sync[1] & ~cmp_prev;

// ----------------------------------------
// dividers: system_clock_source/12 and oscillator/8 as one-cycle enables
// ----------------------------------------
always @(posedge ref_clk) begin
	if (reset) begin
		sys_div <= `DIV_ZERO;
		osc_div <= `OSC_DIV_ZERO;
		osc_div_tick <= 1'b0;
	end else begin
		if (sys_div == `SYS_DIV_LAST)
			sys_div <= `DIV_ZERO;
		else
			sys_div <= sys_div + `DIV_ONE;
		osc_div_tick <= osc_rise && (osc_div == `OSC_DIV_LAST);
		if (osc_rise)
			osc_div <= osc_div + `OSC_DIV_ONE;
	end
end

assign sys12_tick = (sys_div == `SYS_DIV_LAST);

// source selection; one external tick shared by both bytes
always @* begin
	case (external_source_select)
	`SRC_SYS_A: ext_tick = sys12_tick;
	`SRC_EXT_OSC: ext_tick = osc_div_tick;
	`SRC_SYS_B: ext_tick = sys12_tick;
	`SRC_CMP: ext_tick = cmp_rise;
	default: ext_tick = 1'b0;
	endcase
	if (external_source_select[`SRC_MSB])
		cap_tick = osc_div_tick;
	else
		cap_tick = cmp_rise;
end

// ----------------------------------------
// count enables
// ----------------------------------------
// in split mode the low byte ignores run; in 16-bit both obey run
assign low_en = split_mode_select ? 1'b1 : run_control;
assign high_en = run_control;
assign low_step = low_en &&
	(low_byte_clock_pick ? 1'b1 : ext_tick);
assign high_step = high_en &&
	(high_byte_clock_pick ? 1'b1 : ext_tick);
assign low_wrap = (count_value_low == `BYTE_MAX);
assign high_wrap = (count_value_high == `BYTE_MAX);

// next count and overflow events
always @* begin
	next_low = count_value_low;
	next_high = count_value_high;
	next_low_ovf = 1'b0;
	next_high_ovf = 1'b0;
	if (split_mode_select) begin
		if (low_step) begin
			if (low_wrap) begin
				next_low = reload_value_low;
				next_low_ovf = 1'b1;
			end else begin
				next_low = count_value_low + 8'h01;
			end
		end
		if (high_step) begin
			if (high_wrap) begin
				next_high = reload_value_high;
				next_high_ovf = 1'b1;
			end else begin
				next_high = count_value_high + 8'h01;
			end
		end
	end else if (low_step && !capture_enable) begin
		// 16-bit mode is clocked by the low byte clock pick
		if (low_wrap && high_wrap) begin
			next_low = reload_value_low;
			next_high = reload_value_high;
			next_high_ovf = 1'b1;
			next_low_ovf = 1'b1;
		end else if (low_wrap) begin
			next_low = `BYTE_RESET;
			next_high = count_value_high + 8'h01;
			next_low_ovf = 1'b1;
		end else begin
			next_low = count_value_low + 8'h01;
		end
	end else if (low_step) begin
		// capture mode: free-running 16-bit count, no reload
		{next_high, next_low} = {count_value_high, count_value_low}
			+ 16'h0001;
		next_low_ovf = low_wrap;
	end
end

// ----------------------------------------
// registers and sfr writes; hardware sets win over software clears
// ----------------------------------------
always @(posedge ref_clk) begin
	if (reset) begin
		reload_value_low <= `BYTE_RESET;
		reload_value_high <= `BYTE_RESET;
		count_value_low <= `BYTE_RESET;
		count_value_high <= `BYTE_RESET;
		ctrl <= `CTRL_RESET;
	end else begin
		count_value_low <= next_low;
		count_value_high <= next_high;
		if (sfr_wr && sfr_addr == `COUNT_LOW_ADDR)
			count_value_low <= sfr_wdata;
		if (sfr_wr && sfr_addr == `COUNT_HIGH_ADDR)
			count_value_high <= sfr_wdata;
		if (sfr_wr && sfr_addr == `RELOAD_LOW_ADDR)
			reload_value_low <= sfr_wdata;
		if (sfr_wr && sfr_addr == `RELOAD_HIGH_ADDR)
			reload_value_high <= sfr_wdata;
		if (sfr_wr && sfr_addr == `CTRL_ADDR)
			ctrl <= sfr_wdata;
		// capture copies the live count; beats a same-cycle reload write
		if (capture_enable && cap_tick) begin
			reload_value_low <= count_value_low;
			reload_value_high <= count_value_high;
		end
		if (next_low_ovf)
			ctrl[`BIT_LOW_OVF] <= 1'b1;
		if (next_high_ovf || (capture_enable && cap_tick))
			ctrl[`BIT_HIGH_OVF] <= 1'b1;
	end
end

// ----------------------------------------
// read port and interrupt request
// ----------------------------------------
always @(posedge ref_clk) begin
	if (reset) begin
		sfr_rdata <= `BYTE_RESET;
		irq_request <= 1'b0;
	end else begin
		if (sfr_rd) begin
			case (sfr_addr)
			`CTRL_ADDR: sfr_rdata <= ctrl;
			`RELOAD_LOW_ADDR: sfr_rdata <= reload_value_low;
			`RELOAD_HIGH_ADDR: sfr_rdata <= reload_value_high;
			`COUNT_LOW_ADDR: sfr_rdata <= count_value_low;
			`COUNT_HIGH_ADDR: sfr_rdata <= count_value_high;
			default: sfr_rdata <= `BYTE_RESET;
			endcase
		end
		irq_request <= timer_irq_enable && (ctrl[`BIT_HIGH_OVF] ||
			(ctrl[`BIT_LOW_IRQ_EN] && ctrl[`BIT_LOW_OVF]));
	end
end

endmodule // auto_reload_timer_three

// file: verif/timer3_checker.sv
// checker for the timer three register port and interrupt level
`timescale 1ns/10ps
module timer3_checker (
	input wire ref_clk, // system clock
	input wire reset, // sync reset
	input wire [7:0] sfr_addr, // address
	input wire [7:0] sfr_wdata, // write data
	input wire sfr_wr, // write strobe
	input wire sfr_rd, // read strobe
	input wire [7:0] sfr_rdata, // read data
	input wire timer_irq_enable, // irq gate
	input wire irq_request // irq level
);
	// ----------------
	// port relations
	// ----------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// nothing visible survives a reset
	reset_zero_a: assert property (
		$fell(reset) |-> !irq_request && sfr_rdata == 8'h00)
		else $error("state not clear after reset");
	rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	rdata_cause_a: assert property (
		$changed(sfr_rdata) |-> $past(sfr_rd))
		else $error("read data changed with no read before");
	unmapped_zero_a: assert property (
		sfr_rd && (sfr_addr < 8'h91 || sfr_addr > 8'h95) |=>
		sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	// reload bytes are plain storage while capture is off
	reload_back_a: assert property (
		sfr_wr && (sfr_addr == 8'h92 || sfr_addr == 8'h93) ##1 !sfr_wr ##1
		sfr_rd && sfr_addr == $past(sfr_addr, 2) |=>
		sfr_rdata == $past(sfr_wdata, 3))
		else $error("reload byte readback wrong");
	// flags may set at any time, so only the low six bits are compared
	ctrl_back_a: assert property (
		sfr_wr && sfr_addr == 8'h91 ##1 !sfr_wr ##1
		sfr_rd && sfr_addr == 8'h91 |=>
		sfr_rdata[5:0] == $past(sfr_wdata[5:0], 3))
		else $error("control readback wrong");
	irq_gate_a: assert property (!timer_irq_enable |=> !irq_request)
		else $error("irq raised while timer irq disabled");
	irq_cause_a: assert property (
		$rose(irq_request) |-> $past(timer_irq_enable))
		else $error("irq rose without enable");
endmodule // timer3_checker

bind auto_reload_timer_three timer3_checker chk (.ref_clk(ref_clk),
	.reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
	.timer_irq_enable(timer_irq_enable), .irq_request(irq_request));

// file: verif/auto_reload_timer_three_test.sv
// self-checking bench for auto-reload timer three
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares += 1; if ((g) !== (e)) begin \
	n_mismatch += 1; $display("mismatch %s exp %h got %h", nm, e, g); end end
module auto_reload_timer_three_test;
	reg ref_clk = 0, reset = 1, sfr_wr = 0, sfr_rd = 0;
	reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, v, ex;
	reg high_byte_clock_pick = 1, low_byte_clock_pick = 1;
	reg timer_irq_enable = 0, ext_osc_clk = 0, comparator1_out = 0;
	wire [7:0] sfr_rdata;
	wire irq_request;
	integer n_mismatch = 0, compares = 0, cyc = 0, i;
	auto_reload_timer_three dut (.ref_clk(ref_clk), .reset(reset),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.high_byte_clock_pick(high_byte_clock_pick),
		.low_byte_clock_pick(low_byte_clock_pick),
		.timer_irq_enable(timer_irq_enable), .ext_osc_clk(ext_osc_clk),
		.comparator1_out(comparator1_out), .irq_request(irq_request));
	// 50 MHz system clock
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	// ----------------
	// bus cycles
	// ----------------
	task wr(input [7:0] a, input [7:0] d); begin
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
	end endtask
	// data is registered at the taking edge, so look just after it
	task rd(input [7:0] a); begin
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge ref_clk);
		sfr_rd <= 1'b0;
		#1 v = sfr_rdata;
	end endtask
	// ----------------
	// scenarios
	// ----------------
	task t_reset; begin
		for (i = 8'h92; i <= 8'h96; i++) begin
			rd(i[7:0]);
			`CHK("reset value", 8'h00, v)
		end
		$display("t_reset done");
	end endtask
	task t_rw; begin
		for (i = 8'h92; i <= 8'h95; i++) begin
			wr(i[7:0], i[7:0] ^ 8'hA5);
			rd(i[7:0]);
			`CHK("byte readback", i[7:0] ^ 8'hA5, v)
		end
		$display("t_rw done");
	end endtask
	// counts from FFFE through rollover; flags are read while running and
	// the stop write keeps them set, since writing zeros would clear them
	task t_run16; begin
		wr(8'h95, 8'hFF);
		wr(8'h94, 8'hFE);
		wr(8'h93, 8'h12);
		wr(8'h92, 8'h34);
		timer_irq_enable <= 1'b1;
		wr(8'h91, 8'h24);
		@(posedge ref_clk);
		rd(8'h91);
		`CHK("flags 16 bit", 8'hE4, v)
		`CHK("irq level", 1'b1, irq_request)
		wr(8'h91, 8'hE0);
		rd(8'h95);
		`CHK("high reload", 8'h12, v)
		rd(8'h94);
		`CHK("low count", 8'h37, v)
		repeat (5) @(posedge ref_clk);
		rd(8'h94);
		`CHK("held count", 8'h37, v)
		wr(8'h91, 8'h00);
		rd(8'h91);
		`CHK("flags cleared", 8'h00, v)
		`CHK("irq dropped", 1'b0, irq_request)
		$display("t_run16 done");
	end endtask
	// split with run off: only the low byte moves
	task t_split; begin
		wr(8'h95, 8'h50);
		wr(8'h94, 8'hFE);
		wr(8'h92, 8'h80);
		wr(8'h91, 8'h28);
		@(posedge ref_clk);
		rd(8'h91);
		`CHK("split flags", 8'h68, v)
		`CHK("low irq", 1'b1, irq_request)
		wr(8'h91, 8'h00);
		rd(8'h94);
		`CHK("split low", 8'h83, v)
		rd(8'h95);
		`CHK("split high", 8'h50, v)
		$display("t_split done");
	end endtask
	// one comparator edge captures the live count; code 10 ignores it
	task t_capture; begin
		wr(8'h95, 8'h10);
		wr(8'h94, 8'h00);
		wr(8'h91, 8'h14);
		comparator1_out <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd(8'h93);
		`CHK("capture high", 8'h10, v)
		rd(8'h92);
		`CHK("capture low", 8'h02, v)
		rd(8'h91);
		`CHK("capture flag", 8'h94, v)
		`CHK("capture irq", 1'b1, irq_request)
		wr(8'h91, 8'h16);
		comparator1_out <= 1'b0;
		repeat (3) @(posedge ref_clk);
		comparator1_out <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd(8'h92);
		`CHK("no capture", 8'h02, v)
		rd(8'h91);
		`CHK("no capture flag", 8'h16, v)
		wr(8'h91, 8'h00);
		comparator1_out <= 1'b0;
		$display("t_capture done");
	end endtask
	// 98 run cycles, 48 rising edges on each external line
	task t_ext; begin
		low_byte_clock_pick <= 1'b0;
		high_byte_clock_pick <= 1'b0;
		for (i = 0; i < 4; i++) begin
			ex = (i == 3) ? 8'h30 : (i == 1) ? 8'h06 : 8'h08;
			wr(8'h94, 8'h00);
			wr(8'h95, 8'h00);
			wr(8'h91, {6'h01, i[1:0]});
			repeat (96) begin
				@(posedge ref_clk);
				ext_osc_clk <= ~ext_osc_clk;
				comparator1_out <= ~comparator1_out;
			end
			wr(8'h91, 8'h00);
			rd(8'h94);
			`CHK("ext ticks", 1'b1, v + 1 >= ex && v <= ex + 1)
		end
		// split with run: both bytes share the system_clock_source/12 tick
		wr(8'h94, 8'h00);
		wr(8'h95, 8'h00);
		wr(8'h91, 8'h0C);
		repeat (96) @(posedge ref_clk);
		wr(8'h91, 8'h00);
		rd(8'h95);
		ex = v;
		`CHK("split ext high", 1'b1, v >= 8'h07 && v <= 8'h09)
		rd(8'h94);
		`CHK("split ext low", ex, v)
		$display("t_ext done");
	end endtask
	task close_out; begin
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	end endtask
	// hang guard, well above the few hundred cycles the tests need
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch += 1;
			close_out;
		end
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset;
		t_rw;
		t_run16;
		t_split;
		t_capture;
		t_ext;
		close_out;
	end
endmodule // auto_reload_timer_three_test
